// ==== iemb_enable_bank.sv ====
// Interrupt enable register bank with global gate and seven source masks.
// Assumes the core drives the special function bus on core_clk, and that
// the source flags other than the two external interrupt pins come from logic on the same clock.
//
// Function
// R1: Global gate bit 7 at zero blocks every source.
// R2: Global gate at one passes a source only when its mask is set.
// R3: Bit 6 masks serial peripheral port requests.
// R4: Bit 5 masks timer 2; either low or high overflow flag requests.
// R5: Bit 4 masks the first asynchronous serial port.
// R6: Bit 3 masks the timer 1 overflow request.
// R7: Bit 2 masks external interrupt 1 input requests.
// R8: Bit 1 masks the timer 0 overflow request.
// R9: Bit 0 masks external interrupt 0 input requests.
// R10: Register at 0xA8, all pages, bit access, resets to zero.
// R11: Masked request is flag AND mask AND gate; masking keeps flags.
`timescale 1ns/1ps
`include "iemb_params.svh"
module iemb_enable_bank (
  input wire logic core_clk, // System clock, 10 MHz
  input wire logic reset_n, // Asynchronous reset, active low
  input wire logic [7:0] sfrAddr, // Special function address
  input wire logic sfrWrite, // Byte write strobe
  input wire logic [7:0] sfrWdata, // Byte write data
  input wire logic sfrBitWrite, // Single-bit write strobe
  input wire logic [2:0] sfrBitSel, // Bit position for bit write
  input wire logic sfrBitVal, // Value for bit write
  input wire logic sfrRead, // Read strobe
  output logic [7:0] sfrRdata, // Registered read data
  output logic sfrHit, // Address decodes to this register
  input wire logic serialPeriphUnitReq, // Serial peripheral port flag
  input wire logic timer2LowOverflowFlag, // Timer 2 low-byte overflow
  input wire logic timer2HighOverflowFlag, // Timer 2 high-byte overflow
  input wire logic asyncPortUnitReq, // First asynchronous port flag
  input wire logic timer1OverflowFlag, // Timer 1 overflow
  input wire logic extIrq1Pin, // External interrupt 1 request
  input wire logic timer0OverflowFlag, // Timer 0 overflow
  input wire logic extIrq0Pin, // External interrupt 0 request
  output logic [7:0] interruptEnable, // Current enable register value
  output logic [6:0] maskedReq // Masked requests, bit order as register
);

  // ****************************************************************
  // Register storage
  // ****************************************************************
  logic [7:0] enable_q;
  logic [7:0] enable_d;
  logic [7:0] rdata_q;
  logic hit;
  logic ext1Sync1_q;
  logic ext1Sync2_q;
  logic ext0Sync1_q;
  logic ext0Sync2_q;
  iemb_pkg::iemb_acc_t acc;
  iemb_pkg::iemb_src_t flags;

  iemb_gate_if gif ();

  // Decode ignores any page select; the register lives on every page
  assign hit = (sfrAddr == `IEMB_ENABLE_ADDR); // [R10]
  assign sfrHit = hit;

  // Classify the access; a byte write wins over a bit write
  always_comb begin
    if (hit && sfrWrite) begin
      acc = iemb_pkg::IEMB_ACC_BYTE;
    end else if (hit && sfrBitWrite) begin
      acc = iemb_pkg::IEMB_ACC_BIT;
    end else begin
      acc = iemb_pkg::IEMB_ACC_NONE;
    end
  end

  // Next value: whole byte or one bit, others untouched
  always_comb begin
    enable_d = enable_q;
    unique case (acc)
      iemb_pkg::IEMB_ACC_BYTE: begin
        enable_d = sfrWdata;
      end
      iemb_pkg::IEMB_ACC_BIT: begin
        enable_d[sfrBitSel] = sfrBitVal; // [R10]
      end
      iemb_pkg::IEMB_ACC_NONE: begin
        enable_d = enable_q;
      end
      default: begin
        enable_d = enable_q;
      end
    endcase
  end

  // Enable register, cleared at reset
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      enable_q <= `IEMB_ENABLE_RESET; // [R10]
    end else begin
      enable_q <= enable_d;
    end
  end

  // Read data registered; an unmatched read returns zero
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= 8'h00;
    end else if (sfrRead && hit) begin
      rdata_q <= enable_q;
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign sfrRdata = rdata_q;
  assign interruptEnable = enable_q;

  // ****************************************************************
  // External pin synchronisers
  // ****************************************************************
  // External inputs arrive from pins, so two flops guard metastability
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ext1Sync1_q <= 1'b0;
      ext1Sync2_q <= 1'b0;
      ext0Sync1_q <= 1'b0;
      ext0Sync2_q <= 1'b0;
    end else begin
      ext1Sync1_q <= extIrq1Pin;
      ext1Sync2_q <= ext1Sync1_q;
      ext0Sync1_q <= extIrq0Pin;
      ext0Sync2_q <= ext0Sync1_q;
    end
  end

  // ****************************************************************
  // Source flags and masking
  // ****************************************************************
  // Flags are only read here, never cleared, so masking keeps them
  always_comb begin
    flags = '0;
    flags[`IEMB_BIT_SERIAL] = serialPeriphUnitReq; // [R3]
    flags[`IEMB_BIT_TIMER2] = timer2LowOverflowFlag |
                              timer2HighOverflowFlag; // [R4]
    flags[`IEMB_BIT_ASYNC] = asyncPortUnitReq; // [R5]
    flags[`IEMB_BIT_TIMER1] = timer1OverflowFlag; // [R6]
    flags[`IEMB_BIT_EXT1] = ext1Sync2_q; // [R7]
    flags[`IEMB_BIT_TIMER0] = timer0OverflowFlag; // [R8]
    flags[`IEMB_BIT_EXT0] = ext0Sync2_q; // [R9]
  end

  assign gif.globalIrqGate = enable_q[`IEMB_BIT_GATE];
  assign gif.srcMask = enable_q[6:0];
  assign gif.srcFlag = flags;

  iemb_gate u_gate (
    .gif(gif.gate)
  );

  assign maskedReq = gif.maskedReq; // [R11]

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_gate_blocks;
    @(posedge core_clk) disable iff (!reset_n)
      !enable_q[`IEMB_BIT_GATE] |-> (maskedReq == 7'h00);
  endproperty
  a_gate_blocks: assert property (p_gate_blocks) // [R1]
    else $error("Request passed with global gate off");

  property p_gate_passes;
    @(posedge core_clk) disable iff (!reset_n)
      enable_q[`IEMB_BIT_GATE] |-> (maskedReq == (flags & enable_q[6:0]));
  endproperty
  a_gate_passes: assert property (p_gate_passes) // [R2]
    else $error("Masked request wrong with gate on");

  property p_serial;
    @(posedge core_clk) disable iff (!reset_n)
      maskedReq[`IEMB_BIT_SERIAL] == (serialPeriphUnitReq &&
        enable_q[`IEMB_BIT_SERIAL] && enable_q[`IEMB_BIT_GATE]);
  endproperty
  a_serial: assert property (p_serial) // [R3]
    else $error("Serial port request mismatch");

  property p_timer2;
    @(posedge core_clk) disable iff (!reset_n)
      (enable_q[7] && enable_q[`IEMB_BIT_TIMER2] &&
       (timer2LowOverflowFlag || timer2HighOverflowFlag))
        |-> maskedReq[`IEMB_BIT_TIMER2];
  endproperty
  a_timer2: assert property (p_timer2) // [R4]
    else $error("Timer 2 request missing");

  property p_async;
    @(posedge core_clk) disable iff (!reset_n)
      !enable_q[`IEMB_BIT_ASYNC] |-> !maskedReq[`IEMB_BIT_ASYNC];
  endproperty
  a_async: assert property (p_async) // [R5]
    else $error("Async port request not masked");

  property p_timer1;
    @(posedge core_clk) disable iff (!reset_n)
      maskedReq[`IEMB_BIT_TIMER1] |-> timer1OverflowFlag &&
        enable_q[`IEMB_BIT_TIMER1];
  endproperty
  a_timer1: assert property (p_timer1) // [R6]
    else $error("Timer 1 request without cause");

  property p_ext1;
    @(posedge core_clk) disable iff (!reset_n)
      (enable_q[7] && enable_q[`IEMB_BIT_EXT1] && $past(extIrq1Pin, 2)
       && $past(enable_q[7]) && $past(enable_q[7], 2))
        |-> maskedReq[`IEMB_BIT_EXT1];
  endproperty
  a_ext1: assert property (p_ext1) // [R7]
    else $error("External 1 request missing two cycles after pin");

  property p_timer0;
    @(posedge core_clk) disable iff (!reset_n)
      !enable_q[`IEMB_BIT_TIMER0] |-> !maskedReq[`IEMB_BIT_TIMER0];
  endproperty
  a_timer0: assert property (p_timer0) // [R8]
    else $error("Timer 0 request not masked");

  property p_ext0;
    @(posedge core_clk) disable iff (!reset_n)
      maskedReq[`IEMB_BIT_EXT0] |-> $past(extIrq0Pin, 2) &&
        enable_q[`IEMB_BIT_EXT0];
  endproperty
  a_ext0: assert property (p_ext0) // [R9]
    else $error("External 0 request without pin");

  property p_bit_write;
    @(posedge core_clk) disable iff (!reset_n)
      (hit && sfrBitWrite && !sfrWrite) |=>
        (enable_q[$past(sfrBitSel)] == $past(sfrBitVal)) &&
        ((enable_q ^ $past(enable_q)) & ~(8'h01 << $past(sfrBitSel)))
          == 8'h00;
  endproperty
  a_bit_write: assert property (p_bit_write) // [R10]
    else $error("Bit write disturbed other bits");

  property p_byte_write;
    @(posedge core_clk) disable iff (!reset_n)
      (hit && sfrWrite) |=> enable_q == $past(sfrWdata);
  endproperty
  a_byte_write: assert property (p_byte_write) // [R10]
    else $error("Byte write not stored");

  property p_read;
    @(posedge core_clk) disable iff (!reset_n)
      (hit && sfrRead) |=> sfrRdata == $past(enable_q);
  endproperty
  a_read: assert property (p_read) // [R10]
    else $error("Read data wrong");

endmodule : iemb_enable_bank

// ==== iemb_gate.sv ====
// Masking gate: ANDs each source flag with its mask and the global gate.
// Assumes the interface carries registered enables from the bank.
`timescale 1ns/1ps
`include "iemb_params.svh"
module iemb_gate (
  iemb_gate_if.gate gif // Enable and flag bundle
);

  // Pure combinational AND keeps the request in step with the flags
  always_comb begin
    gif.maskedReq = gif.srcFlag & gif.srcMask &
                    {`IEMB_NUM_SRC{gif.globalIrqGate}}; // [R1] [R2] [R11]
  end

endmodule : iemb_gate

// ==== iemb_gate_if.sv ====
// Carries the enable bits and source flags between the bank and its gate.
// Assumes one clock domain; signals are plain levels.
`timescale 1ns/1ps
interface iemb_gate_if;
  logic globalIrqGate;
  iemb_pkg::iemb_src_t srcMask;
  iemb_pkg::iemb_src_t srcFlag;
  iemb_pkg::iemb_src_t maskedReq;
  modport bank (output globalIrqGate, output srcMask, output srcFlag,
                input maskedReq);
  modport gate (input globalIrqGate, input srcMask, input srcFlag,
                output maskedReq);
endinterface : iemb_gate_if

// ==== iemb_params.svh ====
// Constants for the interrupt enable mask bank.
// Assumes inclusion by its bare name from the design files.
`ifndef IEMB_PARAMS_SVH
`define IEMB_PARAMS_SVH

// Special function address of the enable register
`define IEMB_ENABLE_ADDR 8'hA8
// Reset value of the enable register
`define IEMB_ENABLE_RESET 8'h00
// Bit positions inside the enable register
`define IEMB_BIT_GATE 7
`define IEMB_BIT_SERIAL 6
`define IEMB_BIT_TIMER2 5
`define IEMB_BIT_ASYNC 4
`define IEMB_BIT_TIMER1 3
`define IEMB_BIT_EXT1 2
`define IEMB_BIT_TIMER0 1
`define IEMB_BIT_EXT0 0
// Number of maskable sources
`define IEMB_NUM_SRC 7

`endif

// ==== iemb_pkg.sv ====
// Types shared by the interrupt enable mask bank.
// Assumes iemb_params.svh is compiled alongside.
package iemb_pkg;

  // Source request vector, one bit per maskable source
  typedef logic [6:0] iemb_src_t;

  // Kind of special function access
  typedef enum logic [1:0] {
    IEMB_ACC_NONE = 2'b00,
    IEMB_ACC_BYTE = 2'b01,
    IEMB_ACC_BIT = 2'b10
  } iemb_acc_t;

endpackage : iemb_pkg

// ==== iemb_src_model.sv ====
// Behavioural model of the interrupt sources facing the enable bank.
// Assumes the bench pulses set and clear vectors on core_clk.
`timescale 1ns/1ps
module iemb_src_model (
  input wire logic core_clk, // System clock
  input wire logic reset_n, // Asynchronous reset, active low
  input wire logic [7:0] setFlag, // Pulse to raise flags
  input wire logic [7:0] clrFlag, // Pulse to clear flags
  output logic [7:0] flagQ // Pending flags, bit 7 is timer 2 high
);
  // ****
  // Pending flags
  // ****
  // Only an explicit clear or reset drops a flag, so masking cannot lose one
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      flagQ <= 8'h00;
    end else begin
      flagQ <= (flagQ | setFlag) & ~clrFlag;
    end
  end
endmodule : iemb_src_model

// ==== test_interrupt_enable_mask_bank.sv ====
// Self-checking bench for the interrupt enable mask bank.
// Assumes iemb_params.svh, iemb_pkg and the design are compiled first.
`timescale 1ns/1ps
module test_interrupt_enable_mask_bank;
  logic core_clk, reset_n, sfrWrite, sfrBitWrite, sfrBitVal, sfrRead;
  logic sfrHit;
  logic [7:0] sfrAddr, sfrWdata, sfrRdata, interruptEnable;
  logic [7:0] setFlag, clrFlag, flagQ, shadowEn, shadowFlag, rdData;
  logic [2:0] sfrBitSel;
  logic [6:0] maskedReq;
  int errTotal, samplesChecked;

  iemb_src_model src_u (.core_clk(core_clk), .reset_n(reset_n),
    .setFlag(setFlag), .clrFlag(clrFlag), .flagQ(flagQ));
  iemb_enable_bank dut_u (.core_clk(core_clk), .reset_n(reset_n),
    .sfrAddr(sfrAddr), .sfrWrite(sfrWrite), .sfrWdata(sfrWdata),
    .sfrBitWrite(sfrBitWrite), .sfrBitSel(sfrBitSel),
    .sfrBitVal(sfrBitVal), .sfrRead(sfrRead), .sfrRdata(sfrRdata),
    .sfrHit(sfrHit), .serialPeriphUnitReq(flagQ[6]),
    .timer2LowOverflowFlag(flagQ[5]), .timer2HighOverflowFlag(flagQ[7]),
    .asyncPortUnitReq(flagQ[4]), .timer1OverflowFlag(flagQ[3]),
    .extIrq1Pin(flagQ[2]), .timer0OverflowFlag(flagQ[1]),
    .extIrq0Pin(flagQ[0]), .interruptEnable(interruptEnable),
    .maskedReq(maskedReq));

  // ****
  // Clock and shared tasks
  // ****
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task check(input logic [7:0] seen, input logic [7:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      errTotal++;
      $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task printVerdict;
    $display("checks=%0d errors=%0d", samplesChecked, errTotal);
    if (errTotal == 0 && samplesChecked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : printVerdict

  // Byte write; only the mapped address changes the expected value
  task wrByte(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk) #1;
    sfrAddr = a;
    sfrWdata = d;
    sfrWrite = 1'b1;
    @(posedge core_clk) #1;
    sfrWrite = 1'b0;
    if (a == 8'hA8) shadowEn = d;
  endtask : wrByte

  task wrBit(input logic [2:0] b, input logic v);
    @(posedge core_clk) #1;
    sfrAddr = 8'hA8;
    sfrBitSel = b;
    sfrBitVal = v;
    sfrBitWrite = 1'b1;
    @(posedge core_clk) #1;
    sfrBitWrite = 1'b0;
    shadowEn[b] = v;
  endtask : wrBit

  // Read data stands for the one cycle after the strobe
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk) #1;
    sfrAddr = a;
    sfrRead = 1'b1;
    @(posedge core_clk) #1;
    sfrRead = 1'b0;
    d = sfrRdata;
  endtask : rd

  // Waits three edges so the synchronised pin sources settle too
  task flags(input logic [7:0] s, input logic [7:0] c);
    @(posedge core_clk) #1;
    setFlag = s;
    clrFlag = c;
    @(posedge core_clk) #1;
    setFlag = 8'h00;
    clrFlag = 8'h00;
    shadowFlag = (shadowFlag | s) & ~c;
    repeat (3) @(posedge core_clk);
    #1;
  endtask : flags

  // Expected requests from the shadow enable and flag copies
  task chkReq;
    logic [6:0] r;
    r = {shadowFlag[6], shadowFlag[5] | shadowFlag[7], shadowFlag[4:0]};
    check({1'b0, maskedReq}, shadowEn[7] ? {1'b0, r & shadowEn[6:0]} : 8'h00);
  endtask : chkReq

  // ****
  // Main sequence
  // ****
  initial begin
    {reset_n, sfrWrite, sfrBitWrite, sfrBitVal, sfrRead} = 5'h00;
    {sfrAddr, sfrWdata, setFlag, clrFlag, shadowEn, shadowFlag} = 48'h0;
    sfrBitSel = 3'h0;
    errTotal = 0;
    samplesChecked = 0;
    repeat (12) @(posedge core_clk);
    #1 reset_n = 1'b1;
    check(interruptEnable, 8'h00);
    rd(8'hA8, rdData);
    check(rdData, 8'h00);
    check({7'h00, sfrHit}, 8'h01);
    flags(8'hFF, 8'h00);
    chkReq();
    wrByte(8'hA8, 8'h7F);
    chkReq();
    wrBit(3'h7, 1'b1);
    chkReq();
    rd(8'hA8, rdData);
    check(rdData, 8'hFF);
    // Read data stands one cycle only, then falls back to zero
    @(posedge core_clk) #1;
    check(sfrRdata, 8'h00);
    for (int b = 0; b < 7; b++) begin
      wrByte(8'hA8, 8'h80 | (8'h01 << b));
      chkReq();
    end
    wrByte(8'hA8, 8'hA0);
    flags(8'h20, 8'hDF);
    chkReq();
    flags(8'h80, 8'h20);
    chkReq();
    wrByte(8'hA8, 8'hFF);
    flags(8'h7F, 8'h00);
    wrBit(3'h7, 1'b0);
    chkReq();
    wrBit(3'h7, 1'b1);
    chkReq();
    wrByte(8'hA9, 8'h00);
    check(interruptEnable, shadowEn);
    rd(8'hA9, rdData);
    check(rdData, 8'h00);
    check({7'h00, sfrHit}, 8'h00);
    wrBit(3'h5, 1'b0);
    check(interruptEnable, 8'hDF);
    // Bit write to a neighbouring address must be ignored
    @(posedge core_clk) #1;
    sfrAddr = 8'hA9;
    sfrBitSel = 3'h0;
    sfrBitVal = 1'b1;
    sfrBitWrite = 1'b1;
    @(posedge core_clk) #1;
    sfrBitWrite = 1'b0;
    check(interruptEnable, 8'hDF);
    // Byte and bit strobes together: the byte write wins
    @(posedge core_clk) #1;
    sfrAddr = 8'hA8;
    sfrWdata = 8'h5A;
    sfrWrite = 1'b1;
    sfrBitWrite = 1'b1;
    @(posedge core_clk) #1;
    sfrWrite = 1'b0;
    sfrBitWrite = 1'b0;
    check(interruptEnable, 8'h5A);
    // Mid-run reset clears the bank, then the bank works again
    @(posedge core_clk) #1;
    reset_n = 1'b0;
    #1 check(interruptEnable, 8'h00);
    check({1'b0, maskedReq}, 8'h00);
    repeat (2) @(posedge core_clk);
    #1 reset_n = 1'b1;
    shadowFlag = 8'h00;
    wrByte(8'hA8, 8'h81);
    check(interruptEnable, 8'h81);
    // Pin request reaches the core two edges after the pin rises
    @(posedge core_clk) #1;
    setFlag = 8'h01;
    @(posedge core_clk) #1;
    setFlag = 8'h00;
    @(posedge core_clk) #1;
    check({1'b0, maskedReq}, 8'h00);
    @(posedge core_clk) #1;
    check({1'b0, maskedReq}, 8'h01);
    printVerdict();
  end

  // Cuts a hang short
  initial begin
    #2000000;
    errTotal++;
    printVerdict();
  end
endmodule : test_interrupt_enable_mask_bank
